/* hw/tbpw_pwm_top.sv */
// Purpose: Single channel timer based pulse width output with AHB-Lite regs
// Assumes: Zero-wait AHB-Lite slave, byte address = register index * 4
// Notes: Only pulse width mode of the unit is built
//
// Notes on behaviour
// RQ1: Period is (limit+1)*4*prescale oscillator cycles
// RQ2: Count equal limit clears count next increment
// RQ3: Period start sets pin unless duty zero
// RQ4: Period boundary copies buffered duty into shadow
// RQ5: Postscaler never alters output period
// RQ6: Duty is msbs register plus control bits 5:4
// RQ7: Duty writes apply only from next period
// RQ8: Shadow readable, write-ignored in pulse mode
// RQ9: Shadow plus hidden latch double-buffer duty
// RQ10: Pin clears when duty equals extended count
// RQ11: Duty beyond period keeps pin high
// RQ12: Software sets limit, duty, pin, then timer
// RQ13: Prescale divides by 1, 4 or 16
// RQ14: Software clears direction bit 3 for output
// RQ15: Zero unit control forces output latch low
// RQ16: Pin shows modulator only when direction output
// RQ17: One mode encoding enables pulse width mode
// RQ18: Stopped timer holds count and pin level
`timescale 1ns/100ps
module tbpw_pwm_top
    import tbpw_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Shared output pin
    output logic pinOut,
    output logic pinOe_n,
    // Timer period event, unaffected by output period logic
    output logic timerEvent
);
    import tbpw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] intCtrl_ff;
    logic [7:0] irqFlags_ff;
    logic [7:0] irqEn_ff;
    logic [7:0] timerCount_ff;
    logic [7:0] timerCtrl_ff;
    logic [7:0] dutyMsbs_ff;
    logic [7:0] dutyShadow_ff;
    logic [1:0] dutyLatch_ff;
    logic [7:0] unitCtrl_ff;
    logic [7:0] portDir_ff;
    logic [7:0] portData_ff;
    logic [7:0] periodLimit_ff;
    logic [3:0] postCnt_ff;
    logic modOut_ff;
    logic wrPend_ff;
    logic [7:0] wrIdx_ff;
    logic [7:0] rdData;
    logic [7:0] wrByte;
    logic [7:0] addrIdx;
    logic addrOk;
    logic pwmMode;
    logic run;
    logic boundary;
    logic [9:0] nxt_duty;
    logic [9:0] activeDuty;
    logic [9:0] extCount;
    logic wrTimerCount;
    logic wrTimerCtrl;
    logic wrUnitCtrl;
    logic wrDutyMsbs;
    logic wrDutyShadow;
    logic wrPortDir;
    logic wrPortData;
    logic wrPeriod;
    logic wrIntCtrl;
    logic wrIrqFlags;
    logic wrIrqEn;
    logic [3:0] postLimit;
    logic postWrap;
    logic dutyMatch;

    tbpw_tick_if tk();

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    // Only word-aligned low addresses reach the register file
    assign addrIdx = haddr[9:2];
    assign addrOk = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPend_ff <= 1'b0;
            wrIdx_ff <= 8'h00;
        end else if (hready) begin
            wrPend_ff <= hsel && (htrans == HTRANS_NONSEQ) && hwrite
                && addrOk && (hsize == HSIZE_WORD);
            wrIdx_ff <= addrIdx;
        end
    end

    assign wrByte = hwdata[7:0];
    assign wrTimerCount = wrPend_ff && (wrIdx_ff == IDX_TIMER_COUNT);
    assign wrTimerCtrl = wrPend_ff && (wrIdx_ff == IDX_TIMER_CONTROL);
    assign wrUnitCtrl = wrPend_ff && (wrIdx_ff == IDX_UNIT_CONTROL);
    assign wrDutyMsbs = wrPend_ff && (wrIdx_ff == IDX_DUTY_CYCLE_MSBS);
    assign wrDutyShadow = wrPend_ff && (wrIdx_ff == IDX_DUTY_CYCLE_SHADOW);
    assign wrPortDir = wrPend_ff && (wrIdx_ff == IDX_PORT_B_DIRECTION);
    assign wrPortData = wrPend_ff && (wrIdx_ff == IDX_PORT_B_DATA);
    assign wrPeriod = wrPend_ff && (wrIdx_ff == IDX_PERIOD_LIMIT);
    assign wrIntCtrl = wrPend_ff && (wrIdx_ff == IDX_INTERRUPT_CONTROL);
    assign wrIrqFlags = wrPend_ff && (wrIdx_ff == IDX_PERIPHERAL_IRQ_FLAGS);
    assign wrIrqEn = wrPend_ff && (wrIdx_ff == IDX_PERIPHERAL_IRQ_ENABLES);

    // Read data captured in the address phase; unmapped word-aligned low reads give zero, other reads leave hrdata held
    always_comb begin
        case (addrIdx)
            IDX_INTERRUPT_CONTROL: rdData = intCtrl_ff;
            IDX_PERIPHERAL_IRQ_FLAGS: rdData = irqFlags_ff;
            IDX_TIMER_COUNT: rdData = timerCount_ff;
            IDX_TIMER_CONTROL: rdData = timerCtrl_ff;
            IDX_DUTY_CYCLE_MSBS: rdData = dutyMsbs_ff;
            IDX_DUTY_CYCLE_SHADOW: rdData = dutyShadow_ff; // RQ8
            IDX_UNIT_CONTROL: rdData = unitCtrl_ff;
            IDX_PORT_B_DIRECTION: rdData = portDir_ff;
            IDX_PORT_B_DATA: rdData = portData_ff;
            IDX_PERIPHERAL_IRQ_ENABLES: rdData = irqEn_ff;
            IDX_PERIOD_LIMIT: rdData = periodLimit_ff;
            default: rdData = 8'h00;
        endcase
    end

    // Read right behind a write to the same register sees the old byte
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && (htrans == HTRANS_NONSEQ) && !hwrite
            && addrOk) begin
            hrdata <= {24'h000000, rdData};
        end
    end

    // Zero wait: every transfer ends one cycle after its address phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    assign pwmMode = (unitCtrl_ff[3:0] == MODE_PULSE_WIDTH); // RQ17
    assign run = timerCtrl_ff[TC_TIMER_RUN];

    // Any write here also restarts the prescaler phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            timerCtrl_ff <= RST_TIMER_CONTROL;
        end else if (wrTimerCtrl) begin
            timerCtrl_ff <= wrByte & MASK_TIMER_CONTROL;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            unitCtrl_ff <= RST_UNIT_CONTROL;
        end else if (wrUnitCtrl) begin
            unitCtrl_ff <= wrByte & MASK_UNIT_CONTROL;
        end
    end

    // Duty writes are free at any time; they only reach the buffer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dutyMsbs_ff <= RST_ZERO;
        end else if (wrDutyMsbs) begin
            dutyMsbs_ff <= wrByte; // RQ7
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            periodLimit_ff <= RST_PERIOD_LIMIT;
        end else if (wrPeriod) begin
            periodLimit_ff <= wrByte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            portDir_ff <= RST_PORT_B_DIRECTION;
            portData_ff <= RST_ZERO;
            intCtrl_ff <= RST_ZERO;
            irqEn_ff <= RST_ZERO;
        end else begin
            if (wrPortDir) begin
                portDir_ff <= wrByte;
            end
            if (wrPortData) begin
                portData_ff <= wrByte;
            end
            if (wrIntCtrl) begin
                intCtrl_ff <= wrByte;
            end
            if (wrIrqEn) begin
                irqEn_ff <= wrByte & MASK_IRQ;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and timer

    tbpw_prescaler u_prescaler (
        .core_clk(core_clk),
        .rst(rst),
        .run(run), // RQ18
        .prescaleSel(timerCtrl_ff[TC_PRESCALE_HI:0]), // RQ13
        .clearCnt(wrTimerCount || wrTimerCtrl),
        .tk(tk.src)
    );

    // Boundary is the increment that follows count == limit
    assign boundary = tk.tick && (timerCount_ff == periodLimit_ff); // RQ2

    // Software write wins over the period wrap in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            timerCount_ff <= RST_TIMER_COUNT;
        end else if (wrTimerCount) begin
            timerCount_ff <= wrByte;
        end else if (boundary) begin
            timerCount_ff <= 8'h00; // RQ2 RQ1
        end else if (tk.tick) begin
            timerCount_ff <= timerCount_ff + 8'h01;
        end
    end

    // Postscaler only paces the timer event, never the pin
    assign postLimit = timerCtrl_ff[TC_POSTSCALE_HI:TC_POSTSCALE_LO];
    assign postWrap = boundary && (postCnt_ff == postLimit); // RQ5

    // Lowering the limit under a running count costs one long wrap
    always_ff @(posedge core_clk) begin
        if (rst) begin
            postCnt_ff <= 4'h0;
        end else if (postWrap) begin
            postCnt_ff <= 4'h0;
        end else if (boundary) begin
            postCnt_ff <= postCnt_ff + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timerEvent <= 1'b0;
        end else begin
            timerEvent <= postWrap;
        end
    end

    // Event set beats a software clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irqFlags_ff <= RST_IRQ_FLAGS;
        end else begin
            if (wrIrqFlags) begin
                irqFlags_ff <= wrByte & MASK_IRQ;
            end
            if (postWrap) begin
                irqFlags_ff[IRQF_TIMER_MATCH] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Duty double buffer and compare

    assign nxt_duty = {dutyMsbs_ff, unitCtrl_ff[UC_DUTY_LSB_HIGH],
        unitCtrl_ff[UC_DUTY_LSB_LOW]}; // RQ6
    assign activeDuty = {dutyShadow_ff, dutyLatch_ff}; // RQ9
    assign extCount = {timerCount_ff, tk.phase};

    // Boundary load wins; software writes land only outside pulse mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dutyShadow_ff <= RST_ZERO;
            dutyLatch_ff <= 2'h0;
        end else if (boundary) begin
            dutyShadow_ff <= nxt_duty[9:2]; // RQ4 RQ9
            dutyLatch_ff <= nxt_duty[1:0]; // RQ4
        end else if (wrDutyShadow && !pwmMode) begin
            dutyShadow_ff <= wrByte; // RQ8
        end
    end

    // Compare runs each oscillator cycle on the running extended count
    // Pin stage sees the match too, so high time ends exactly at duty
    // Duty past the period never matches, so the pin stays high
    assign dutyMatch = run && (activeDuty == extCount); // RQ10 RQ11

    always_ff @(posedge core_clk) begin
        if (rst) begin
            modOut_ff <= 1'b0;
        end else if (unitCtrl_ff == RST_UNIT_CONTROL || !pwmMode) begin
            modOut_ff <= 1'b0; // RQ15 RQ17
        end else if (boundary) begin
            modOut_ff <= (nxt_duty != 10'h000); // RQ3
        end else if (dutyMatch) begin
            modOut_ff <= 1'b0; // RQ10 RQ11 RQ18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin mux

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinOut <= 1'b0;
            pinOe_n <= 1'b1;
        end else begin
            // Match taken here directly, else the pulse runs one cycle long
            pinOut <= pwmMode ? (modOut_ff && !dutyMatch)
                : portData_ff[PIN_BIT]; // RQ16 RQ10
            pinOe_n <= portDir_ff[PIN_BIT]; // RQ16 RQ14
        end
    end
endmodule // tbpw_pwm_top

/* hw/tbpw_pkg.sv */
// Purpose: Shared constants for the timer based pulse width output block
// Assumes: AHB-Lite word per register, byte addresses = printed offset * 4
// Notes: Only the low byte of each word is implemented
package tbpw_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
    localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_TIMER_COUNT = 8'h11;
    localparam logic [7:0] IDX_TIMER_CONTROL = 8'h12;
    localparam logic [7:0] IDX_DUTY_CYCLE_MSBS = 8'h15;
    localparam logic [7:0] IDX_DUTY_CYCLE_SHADOW = 8'h16;
    localparam logic [7:0] IDX_UNIT_CONTROL = 8'h17;
    localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h86;
    localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_PERIOD_LIMIT = 8'h92;
    localparam logic [7:0] IDX_PORT_B_DATA = 8'h06;
    // Reset values
    localparam logic [7:0] RST_TIMER_COUNT = 8'h00;
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_UNIT_CONTROL = 8'h00;
    localparam logic [7:0] RST_PORT_B_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
    // Field positions
    localparam int UC_DUTY_LSB_HIGH = 5;
    localparam int UC_DUTY_LSB_LOW = 4;
    localparam int TC_TIMER_RUN = 2;
    localparam int TC_PRESCALE_HI = 1;
    localparam int TC_POSTSCALE_LO = 3;
    localparam int TC_POSTSCALE_HI = 6;
    localparam int PIN_BIT = 3;
    localparam int IRQF_TIMER_MATCH = 1;
    // Masks of implemented bits
    localparam logic [7:0] MASK_TIMER_CONTROL = 8'h7F;
    localparam logic [7:0] MASK_UNIT_CONTROL = 8'h3F;
    localparam logic [7:0] MASK_IRQ = 8'hF7;
    // Mode encoding of mode_select selecting pulse width mode
    localparam logic [3:0] MODE_PULSE_WIDTH = 4'hC;
    // Oscillator periods per timer increment, and prescale divides
    localparam int OSC_PER_INC = 4;
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV4 = 2'h1;
    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* hw/tbpw_tick_if.sv */
// Purpose: Carries timer tick and phase from prescaler to generator
// Assumes: Single clock core_clk
// Notes: One-cycle tick pulse, two-bit phase level
`timescale 1ns/100ps
interface tbpw_tick_if;
    logic tick;
    logic [1:0] phase;
    modport src (output tick, output phase);
    modport dst (input tick, input phase);
endinterface // tbpw_tick_if

/* hw/tbpw_prescaler.sv */
// Purpose: Quarter-cycle phase and timer prescaler for the generator
// Assumes: One core_clk cycle stands for one oscillator period
// Notes: Tick fires once per 4 * prescale oscillator periods
`timescale 1ns/100ps
module tbpw_prescaler
    import tbpw_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [1:0] prescaleSel,
    input wire logic clearCnt,
    // Tick out
    tbpw_tick_if.src tk
);
    logic [5:0] cnt_ff;
    logic [5:0] lastCnt;

    always_comb begin
        case (prescaleSel)
            PS_DIV1: lastCnt = 6'(OSC_PER_INC - 1);
            PS_DIV4: lastCnt = 6'(OSC_PER_INC * 4 - 1);
            default: lastCnt = 6'(OSC_PER_INC * 16 - 1);
        endcase
    end

    // Counter freezes with the timer so phase never drifts while stopped
    always_ff @(posedge core_clk) begin
        if (rst || clearCnt) begin
            cnt_ff <= 6'h00;
        end else if (run) begin
            cnt_ff <= (cnt_ff >= lastCnt) ? 6'h00 : cnt_ff + 6'h01;
        end
    end

    assign tk.tick = run && (cnt_ff >= lastCnt);
    // Low two bits: Q phase for 1:1, prescaler bits for larger divides
    always_comb begin
        case (prescaleSel)
            PS_DIV1: tk.phase = cnt_ff[1:0];
            PS_DIV4: tk.phase = cnt_ff[3:2];
            default: tk.phase = cnt_ff[5:4];
        endcase
    end
endmodule // tbpw_prescaler

/* test/tbpw_checker.sv */
// Purpose: Port level checks for the pulse width output block
// Assumes: Zero-wait bus, byte address = register index * 4
// Notes: Sees only the top module ports; bound below
`timescale 1ns/100ps
module tbpw_checker
    import tbpw_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pin and event
    input wire logic pinOut,
    input wire logic pinOe_n,
    input wire logic timerEvent
);
    localparam logic [31:0] ADDR_DIR = {22'h0, IDX_PORT_B_DIRECTION, 2'h0};
    localparam logic [31:0] ADDR_FREE = 32'h0000_0100;
    logic take;
    logic wrPend_ff;
    logic [31:0] wrAddr_ff;
    assign take = hsel && htrans == HTRANS_NONSEQ && hready;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPend_ff <= 1'b0;
        end else begin
            wrPend_ff <= take && hwrite;
        end
    end
    always_ff @(posedge core_clk) begin
        wrAddr_ff <= haddr;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ready_up_a: assert property (!$past(rst) |-> hreadyout)
        else $error("hreadyout low outside reset");
    resp_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits set");
    rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("hrdata changed without read");
    free_read_a: assert property
        (take && !hwrite && haddr == ADDR_FREE |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    reset_pins_a: assert property ($past(rst) |-> pinOe_n && !pinOut)
        else $error("pin not idle after reset");
    oe_drive_a: assert property (wrPend_ff && wrAddr_ff == ADDR_DIR
        && !hwdata[PIN_BIT] |-> ##[1:2] !pinOe_n)
        else $error("pin enable not driving");
    oe_release_a: assert property (wrPend_ff && wrAddr_ff == ADDR_DIR
        && hwdata[PIN_BIT] |-> ##[1:2] pinOe_n)
        else $error("pin enable not released");
    event_pulse_a: assert property (timerEvent |=> (!timerEvent)[*3])
        else $error("timer event too long");
    pin_gap_a: assert property ($rose(pinOut) |=> (!$rose(pinOut))[*3])
        else $error("pin periods too close");
    cover property ($rose(pinOut));
    cover property (timerEvent);
    cover property (wrPend_ff && wrAddr_ff == ADDR_DIR);
endmodule // tbpw_checker

bind tbpw_pwm_top tbpw_checker tbpw_checker_i (.core_clk(core_clk),
    .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pinOut(pinOut),
    .pinOe_n(pinOe_n), .timerEvent(timerEvent));

/* test/tb_top.sv */
// Purpose: Self-checking bench for the pulse width output block
// Assumes: One core_clk cycle per oscillator period
// Notes: Monitor queues hold period and high time of each period
`timescale 1ns/100ps
module tb_top;
    import tbpw_pkg::*;
    logic core_clk, rst, hsel, hwrite, hreadyout, hresp, pinOut, pinOe_n;
    logic timerEvent, prevPin;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] rd, rd2;
    logic [7:0] rIdx[8] = '{8'h11, 8'h12, 8'h17, 8'h86, 8'h92, 8'h0C, 8'h8C,
        8'h40};
    logic [7:0] rExp[8] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
        8'h00};
    int fails, n_checks, perCnt, hiCnt, evCnt, seed, d, dNew, s;
    int perQ[$], hiQ[$], evQ[$];
    localparam int P = 7;
    tbpw_pwm_top tbpw_pwm_top_i (.core_clk(core_clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pinOut(pinOut),
        .pinOe_n(pinOe_n), .timerEvent(timerEvent));
    always #20 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    // Monitor: period, high time and events per pin period
    always @(posedge core_clk) begin
        if (pinOut === 1'b1 && prevPin === 1'b0) begin
            perQ.push_back(perCnt);
            hiQ.push_back(hiCnt);
            evQ.push_back(evCnt);
            perCnt = 1;
            hiCnt = 1;
            evCnt = 0;
        end else begin
            perCnt++;
            if (pinOut === 1'b1) hiCnt++;
        end
        if (timerEvent === 1'b1) evCnt++;
        prevPin = pinOut;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx,
        input logic [7:0] wd, output logic [7:0] q);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata[7:0];
    endtask
    task automatic busw(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] q;
        bus(1'b1, idx, wd, q);
    endtask
    task automatic setDuty(input int v);
        busw(IDX_DUTY_CYCLE_MSBS, v[9:2]);
        busw(IDX_UNIT_CONTROL, {2'h0, v[1:0], MODE_PULSE_WIDTH});
    endtask
    task automatic waitRises(input int n);
        perQ.delete();
        hiQ.delete();
        evQ.delete();
        for (int i = 0; i < 6000 && perQ.size() < n; i++) @(posedge core_clk);
        chk(perQ.size(), n);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge core_clk);
        fails++;
        finish_test;
    end
    initial begin
        core_clk = 0; rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
        hsize = HSIZE_WORD; hwdata = 0; prevPin = 0; seed = 32'h1230c8ab;
        fails = 0; n_checks = 0; perCnt = 0; hiCnt = 0; evCnt = 0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, rIdx[i], 8'h00, rd);
            chk(rd, rExp[i]);
        end
        // Setup order: limit, duty, pin, then timer
        busw(IDX_PERIOD_LIMIT, P);
        bus(1'b0, IDX_PERIOD_LIMIT, 8'h00, rd);
        chk(rd, P);
        d = 8 + ($unsigned($random(seed)) % 24);
        setDuty(d);
        busw(IDX_PORT_B_DIRECTION, 8'hF7);
        repeat (3) @(posedge core_clk);
        chk(pinOe_n, 1'b0);
        for (int ps = 0; ps < 3; ps++) begin
            busw(IDX_TIMER_CONTROL, 8'h04 | ps);
            waitRises(3);
            chk(perQ[2], (P + 1) * 4 * (ps == 0 ? 1 : ps == 1 ? 4 : 16));
            if (ps == 0) chk(hiQ[2], d);
            bus(1'b0, IDX_TIMER_COUNT, 8'h00, rd);
            chk(rd <= P, 1'b1);
        end
        busw(IDX_TIMER_CONTROL, 8'h1C);
        waitRises(9);
        chk(perQ[8], (P + 1) * 4);
        s = 0;
        for (int i = 1; i < 9; i++) s += evQ[i];
        chk(s, 2);
        bus(1'b0, IDX_DUTY_CYCLE_SHADOW, 8'h00, rd);
        chk(rd, d[9:2]);
        busw(IDX_DUTY_CYCLE_SHADOW, 8'hA5);
        bus(1'b0, IDX_DUTY_CYCLE_SHADOW, 8'h00, rd);
        chk(rd, d[9:2]);
        // New duty written early in a period waits for its end
        waitRises(1);
        dNew = 1 + ($unsigned($random(seed)) % 31);
        setDuty(dNew);
        waitRises(2);
        chk(hiQ[0], d);
        chk(hiQ[1], dNew);
        for (int k = 0; k <= 32; k += 32) begin
            setDuty(k);
            repeat (100) @(posedge core_clk);
            perQ.delete();
            repeat (100) @(posedge core_clk);
            chk(perQ.size(), 0);
            chk(pinOut, k != 0);
        end
        busw(IDX_TIMER_CONTROL, 8'h00);
        bus(1'b0, IDX_TIMER_COUNT, 8'h00, rd);
        repeat (40) @(posedge core_clk);
        bus(1'b0, IDX_TIMER_COUNT, 8'h00, rd2);
        chk(rd2, rd);
        chk(pinOut, 1'b1);
        for (int pd = 0; pd <= 8; pd += 8) begin
            for (int uc = 0; uc <= 8; uc += 8) begin
                busw(IDX_PORT_B_DATA, pd);
                busw(IDX_UNIT_CONTROL, uc);
                repeat (3) @(posedge core_clk);
                chk(pinOut, pd[3]);
            end
        end
        // Pulse mode again, timer stopped: latch must have been forced low
        busw(IDX_UNIT_CONTROL, {4'h0, MODE_PULSE_WIDTH});
        repeat (3) @(posedge core_clk);
        chk(pinOut, 1'b0);
        busw(IDX_PORT_B_DIRECTION, 8'hFF);
        repeat (3) @(posedge core_clk);
        chk(pinOe_n, 1'b1);
        finish_test;
    end
endmodule // tb_top
